// >>> rtl/dsc_pkg.sv
// Shared constants and types for the serial converter control block
package dsc_pkg;
  // ==========================================
  // Frame layout
  localparam int FRAME_BITS = 24;
  localparam int CMD_W = 8;
  localparam int CODE_W = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam int OP_HI = 7;
  localparam int OP_LO = 4;

  // ==========================================
  // Command opcodes, upper nibble of the command byte
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_WRITE_UPDATE = 4'h2;
  localparam logic [3:0] OP_WRITE_ALL = 4'h3;
  localparam logic [3:0] OP_SOFT_LOAD = 4'h4;
  localparam logic [3:0] OP_SOFT_CLEAR = 4'h5;
  localparam logic [3:0] OP_POWER_DOWN = 4'h6;
  localparam logic [3:0] OP_SET_MODE = 4'h7;
  localparam logic [3:0] OP_READ_PRELOAD = 4'h8;
  localparam logic [3:0] OP_READ_OUTPUT = 4'h9;
  localparam logic [3:0] OP_READ_CONFIG = 4'hA;

  // ==========================================
  // Data field positions and defaults
  localparam int PD_HIZ_BIT = 0;
  localparam int PD_10K_BIT = 1;
  localparam int MODE_BIT = 0;
  localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_MID = 16'h8000;
  localparam logic [1:0] POR_HOLD = 2'h3;

  // ==========================================
  // Carriers
  typedef struct packed {
    logic [CMD_W-1:0] cmd;
    logic [CODE_W-1:0] data;
  } dsc_frame_s;

  typedef struct packed {
    logic write_mode;
    logic sel_10k;
    logic sel_hiz;
  } dsc_cfg_s;
endpackage

// >>> rtl/dsc_top.sv
// Serial control logic of a single channel 16-bit voltage converter
// ==========================================
// Functional notes
// - Frame starts at select fall, samples rising
// - Serial output changes on falling edges only
// - Fewer than 24 rising edges: discard frame
// - Extra bits flow; decode last 24 bits
// - 24-bit FIFO shift, MSB first, old out
// - Serial output released while select high
// - Select fall drives shift register MSB
// - Frame is command byte then data word
// - Read loads command copy and register
// - Decode needs a 24-bit count only; chains work
// - Power-up code zero or midscale by pin
// - Write-block: plain writes reach preload only
// - Soft or pin load copies preload out
// - Update and all-write load both registers
// - Write-through: writes update both registers
// - Action uses decode plus load pin level
// - Power-down selects high-Z or 10k pull
// - Load pin low moves preload continuously
// - Plain write target set by mode bit
// - Clear pin or command forces default code
`timescale 1ns/1ps
module dsc_top
  import dsc_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // System
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic chip_select_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Control pins
  input wire logic load_pin_n_i,
  input wire logic clear_pin_n_i,
  input wire logic powerup_value_pin_i,
  // Converter side
  output logic [CODE_W-1:0] dac_code_o,
  output logic [CODE_W-1:0] preload_o,
  output logic amp_enable_o,
  output logic out_hiz_o,
  output logic out_pulldown_o,
  output logic write_mode_o
);

  if (SYNC_STAGES != 2) begin : g_chk
    $error("dsc_top: SYNC_STAGES must be 2");
  end

  // ==========================================
  // Select-fall domain
  // Read data is quasi-static here: the decode that set it ended long before the next fall
  logic frame_tog_reg = 1'b0;
  logic rd_taken_reg = 1'b0;
  logic load_now_reg = 1'b0;
  logic rd_req_tog_reg;
  logic [FRAME_BITS-1:0] rd_word_reg;

  always_ff @(negedge chip_select_n_i) begin
    frame_tog_reg <= ~frame_tog_reg;
    load_now_reg <= rd_req_tog_reg ^ rd_taken_reg;
    rd_taken_reg <= rd_req_tog_reg;
  end

  // ==========================================
  // Serial clock domain
  logic [FRAME_BITS-1:0] shreg_reg = '0;
  logic [FRAME_BITS-1:0] shreg_next;
  logic [CNT_W-1:0] cnt_reg = '0;
  logic [CNT_W-1:0] cnt_next;
  // Toggles start equal to the select-fall toggle so the first frame is seen as new
  logic pos_tog_reg = 1'b0;
  logic pos_tog_next;
  logic hold_reg = 1'b0;
  logic hold_next;
  logic first;
  logic [FRAME_BITS-1:0] base;

  always_comb begin
    first = pos_tog_reg != frame_tog_reg;
    base = (first && load_now_reg) ? rd_word_reg : shreg_reg;
    shreg_next = shreg_reg;
    cnt_next = cnt_reg;
    pos_tog_next = pos_tog_reg;
    hold_next = hold_reg;
    if (!chip_select_n_i) begin
      shreg_next = {base[FRAME_BITS-2:0], sdi_i};
      hold_next = base[FRAME_BITS-1];
      pos_tog_next = frame_tog_reg;
      if (first) begin
        cnt_next = CNT_ONE;
      end else if (cnt_reg != CNT_FULL) begin
        cnt_next = cnt_reg + CNT_ONE;
      end
    end
  end

  always_ff @(posedge sclk_i) begin
    shreg_reg <= shreg_next;
    cnt_reg <= cnt_next;
    pos_tog_reg <= pos_tog_next;
    hold_reg <= hold_next;
  end

  logic neg_tog_reg = 1'b0;
  logic neg_tog_next;
  logic sdo_neg_reg = 1'b0;
  logic sdo_neg_next;

  always_comb begin
    neg_tog_next = neg_tog_reg;
    sdo_neg_next = sdo_neg_reg;
    if (!chip_select_n_i) begin
      neg_tog_next = pos_tog_reg;
      sdo_neg_next = shreg_reg[FRAME_BITS-1];
    end
  end

  always_ff @(negedge sclk_i) begin
    neg_tog_reg <= neg_tog_next;
    sdo_neg_reg <= sdo_neg_next;
  end

  always_comb begin
    if (neg_tog_reg == frame_tog_reg) begin
      sdo_o = sdo_neg_reg;
    end else if (pos_tog_reg == frame_tog_reg) begin
      sdo_o = hold_reg;
    end else if (load_now_reg) begin
      sdo_o = rd_word_reg[FRAME_BITS-1];
    end else begin
      sdo_o = shreg_reg[FRAME_BITS-1];
    end
  end
  assign sdo_oe_o = ~chip_select_n_i;

  // ==========================================
  // Pin synchronisers, first stage feeds only the second
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] pins;
  logic cs_prev_reg;
  assign pins = {chip_select_n_i, load_pin_n_i, clear_pin_n_i, powerup_value_pin_i};

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
      cs_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      cs_prev_reg <= sync2_reg[3];
    end
  end

  logic cs_n_s;
  logic ld_n_s;
  logic clr_n_s;
  logic pu_s;
  logic cs_rise;
  assign cs_n_s = sync2_reg[3];
  assign ld_n_s = sync2_reg[2];
  assign clr_n_s = sync2_reg[1];
  assign pu_s = sync2_reg[0];
  assign cs_rise = cs_n_s & ~cs_prev_reg;

  // ==========================================
  // Decode and register update
  dsc_frame_s frame;
  logic [3:0] op;
  logic frame_ok;
  logic dec_go;
  logic clr_act;
  logic [CODE_W-1:0] dflt;
  assign frame = dsc_frame_s'(shreg_reg);
  assign op = frame.cmd[OP_HI:OP_LO];
  assign frame_ok = (cnt_reg == CNT_FULL) && (pos_tog_reg == frame_tog_reg);
  assign dec_go = cs_rise & frame_ok;

  logic [CODE_W-1:0] pre_reg, pre_next;
  logic [CODE_W-1:0] out_reg, out_next;
  dsc_cfg_s cfg_reg, cfg_next;
  logic [1:0] por_reg, por_next;
  logic rd_req_next;
  logic [FRAME_BITS-1:0] rd_word_next;
  logic soft_clr;

  assign dflt = pu_s ? CODE_MID : CODE_ZERO;
  assign clr_act = ~clr_n_s | (por_reg != 2'h0) | soft_clr;

  always_comb begin
    pre_next = pre_reg;
    out_next = out_reg;
    cfg_next = cfg_reg;
    rd_req_next = rd_req_tog_reg;
    rd_word_next = rd_word_reg;
    por_next = (por_reg != 2'h0) ? por_reg - 2'h1 : por_reg;
    soft_clr = 1'b0;
    // decoded action first, pin level after
    if (dec_go) begin
      case (op)
        OP_WRITE: begin
          pre_next = frame.data;
          if (cfg_reg.write_mode) begin
            out_next = frame.data;
          end
        end
        OP_WRITE_UPDATE, OP_WRITE_ALL: begin
          pre_next = frame.data;
          out_next = frame.data;
        end
        OP_SOFT_LOAD: out_next = pre_reg;
        OP_SOFT_CLEAR: soft_clr = 1'b1;
        OP_POWER_DOWN: begin
          cfg_next.sel_hiz = frame.data[PD_HIZ_BIT];
          cfg_next.sel_10k = frame.data[PD_10K_BIT];
        end
        OP_SET_MODE: cfg_next.write_mode = frame.data[MODE_BIT];
        OP_READ_PRELOAD: begin
          rd_word_next = {frame.cmd, pre_reg};
          rd_req_next = ~rd_req_tog_reg;
        end
        OP_READ_OUTPUT: begin
          rd_word_next = {frame.cmd, out_reg};
          rd_req_next = ~rd_req_tog_reg;
        end
        OP_READ_CONFIG: begin
          rd_word_next = {frame.cmd, 13'h0000, cfg_reg};
          rd_req_next = ~rd_req_tog_reg;
        end
        default: ;
      endcase
    end
    if (!ld_n_s) begin
      out_next = pre_next;
    end
    if (clr_act) begin
      out_next = dflt;
    end
  end

  // registers move only on decode, pins or the power-up count
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pre_reg <= CODE_ZERO;
      out_reg <= CODE_ZERO;
      cfg_reg <= '0;
      por_reg <= POR_HOLD;
      rd_req_tog_reg <= 1'b0;
      rd_word_reg <= '0;
    end else begin
      pre_reg <= pre_next;
      out_reg <= out_next;
      cfg_reg <= cfg_next;
      por_reg <= por_next;
      rd_req_tog_reg <= rd_req_next;
      rd_word_reg <= rd_word_next;
    end
  end

  assign dac_code_o = out_reg;
  assign preload_o = pre_reg;
  assign amp_enable_o = ~(cfg_reg.sel_hiz | cfg_reg.sel_10k);
  assign out_hiz_o = cfg_reg.sel_hiz;
  assign out_pulldown_o = cfg_reg.sel_10k & ~cfg_reg.sel_hiz;
  assign write_mode_o = cfg_reg.write_mode;

  // ==========================================
  // Checks
  logic plain_write;
  assign plain_write = dec_go && op == OP_WRITE && ld_n_s && !clr_act;

  thru_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    plain_write && cfg_reg.write_mode |=> out_reg == $past(frame.data) && pre_reg == out_reg)
    else $error("write-through did not update output");

  block_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    plain_write && !cfg_reg.write_mode |=> out_reg == $past(out_reg) && pre_reg == $past(frame.data))
    else $error("write-block changed output");

  both_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    dec_go && (op == OP_WRITE_UPDATE || op == OP_WRITE_ALL) && !clr_act
    |=> out_reg == $past(frame.data) && pre_reg == $past(frame.data))
    else $error("update write missed a register");

  pin_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ld_n_s && !clr_act && !dec_go |=> out_reg == $past(pre_reg))
    else $error("load pin did not move preload");

  clear_force_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !clr_n_s |=> out_reg == (($past(pu_s)) ? CODE_MID : CODE_ZERO))
    else $error("clear did not force default");

  abort_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cs_rise && !frame_ok && ld_n_s && !clr_act ##1 1'b1
    |-> pre_reg == $past(pre_reg) && out_reg == $past(out_reg) && cfg_reg == $past(cfg_reg))
    else $error("aborted frame changed state");

  read_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    dec_go && op == OP_READ_PRELOAD
    |=> rd_req_tog_reg != $past(rd_req_tog_reg) && rd_word_reg == {$past(frame.cmd), $past(pre_reg)})
    else $error("read did not load FIFO word");

  pd_out_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    dec_go && op == OP_POWER_DOWN && frame.data[PD_HIZ_BIT] |=> out_hiz_o && !amp_enable_o)
    else $error("power-down high-Z not applied");

  sdo_rel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cs_n_s && $past(cs_n_s) && chip_select_n_i |-> !sdo_oe_o)
    else $error("serial output driven while deselected");

  por_dflt_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    por_reg == 2'h1 |=> out_reg == (($past(pu_s)) ? CODE_MID : CODE_ZERO))
    else $error("power-up default wrong");

endmodule

// >>> testbench/dsc_spi_master.sv
// Serial link master model that drives frames into the converter block
`timescale 1ns/1ps
module dsc_spi_master (
  // Link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  // Returned data
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  // ==========================================
  // Idle state: clock parked low, select high
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // ==========================================
  // Frame of n bits, MSB first, 12 ns link clock
  // master owns every line but the returned data, no handshake
  task automatic frame(input logic [63:0] v, input int n, output logic [63:0] got);
    got = '0;
    cs_n_o = 1'b0;
    #6;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = v[i];
      #6;
      // device samples on the rising edge
      sclk_o = 1'b1;
      got = {got[62:0], sdo_oe_i ? sdo_i : 1'bx};
      #6;
      sclk_o = 1'b0;
    end
    #6;
    cs_n_o = 1'b1;
    // Released data line toggles so a stale level is never relied on
    sdi_o = ~sdi_o;
  endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench of the serial converter control block
`timescale 1ns/1ps
module tb_top;
  import dsc_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sclk, cs_n, sdi, sdo_o, sdo_oe_o;
  logic load_pin_n_i = 1'b1;
  logic clear_pin_n_i = 1'b1;
  logic powerup_value_pin_i = 1'b1;
  logic [CODE_W-1:0] dac_code_o, preload_o;
  logic amp_enable_o, out_hiz_o, out_pulldown_o, write_mode_o;
  int fails = 0;
  int samples_checked = 0;
  int pre = 0, dac = CODE_MID, def = CODE_MID, mode = 0, hiz = 0, pd = 0, fifo = 0;
  int seed = 56;
  bit known = 0;

  always #5 clk_i = ~clk_i;

  dsc_top dsc_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .chip_select_n_i(cs_n),
    .sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .load_pin_n_i(load_pin_n_i),
    .clear_pin_n_i(clear_pin_n_i), .powerup_value_pin_i(powerup_value_pin_i),
    .dac_code_o(dac_code_o), .preload_o(preload_o), .amp_enable_o(amp_enable_o),
    .out_hiz_o(out_hiz_o), .out_pulldown_o(out_pulldown_o), .write_mode_o(write_mode_o));
  dsc_spi_master master_i (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o));

  // ==========================================
  // Helpers
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmp_all();
    check(dac_code_o, dac);
    check(preload_o, pre);
    check(write_mode_o, mode);
    check(out_hiz_o, hiz);
    check(out_pulldown_o, pd & ~hiz);
    check(amp_enable_o, (hiz | pd) == 0);
  endtask

  // ==========================================
  // Reference model of one decoded frame
  task automatic decode(input int c, input int d);
    case (c >> 4)
      1: begin
        pre = d;
        if (mode) dac = d;
      end
      2, 3: begin
        pre = d;
        dac = d;
      end
      4: dac = pre;
      5: dac = def;
      6: begin
        hiz = d & 1;
        pd = (d >> 1) & 1;
      end
      7: mode = d & 1;
      8: fifo = (c << 16) | pre;
      9: fifo = (c << 16) | dac;
      10: fifo = (c << 16) | (mode << 2) | (pd << 1) | hiz;
      default: ;
    endcase
  endtask

  task automatic xfer(input logic [63:0] v, input int n);
    logic [63:0] got;
    logic [63:0] mask;
    int k;
    @(posedge clk_i);
    #1;
    master_i.frame(v, n, got);
    #1;
    k = (n < 24) ? n : 24;
    mask = (64'h1 << (n - k)) - 64'h1;
    if (known) check(32'(got >> (n - k)), fifo >> (24 - k));
    if (n > 24) check(32'(got & mask), 32'((v >> 24) & mask));
    check(sdo_oe_o, 1'b0);
    for (int i = n - 1; i >= 0; i--) fifo = ((fifo << 1) | v[i]) & 32'hFFFFFF;
    if (n >= 24) begin
      known = 1;
      decode(fifo >> 16, fifo & 16'hFFFF);
    end
    repeat (8) @(posedge clk_i);
    #1;
    cmp_all();
  endtask

  task automatic cmd(input int op, input int d);
    xfer({op[3:0], 4'h0, d[15:0]}, 24);
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================
  // Watchdog, far beyond the expected run of about 9 us
  initial begin
    #100000;
    fails++;
    stop_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    cmp_all();
    cmd(1, rnd());
    cmd(4, 0);
    // read then a second frame returns the word
    cmd(8, 0);
    cmd(9, 0);
    cmd(10, 0);
    cmd(2, rnd());
    cmd(3, rnd());
    xfer(rnd(), 20);
    xfer({8'hAB, 8'h10, 16'(rnd())}, 32);
    xfer({8'h20, 16'(rnd()), 8'h10, 16'(rnd())}, 48);
    cmd(7, 1);
    cmd(1, rnd());
    cmd(10, 0);
    cmd(6, 1);
    cmd(6, 2);
    cmd(6, 3);
    cmd(6, 0);
    cmd(7, 0);
    cmd(1, rnd());
    // Pins change only while select is high
    load_pin_n_i = 1'b0;
    dac = pre;
    repeat (6) @(posedge clk_i);
    #1;
    cmp_all();
    load_pin_n_i = 1'b1;
    powerup_value_pin_i = 1'b0;
    def = CODE_ZERO;
    clear_pin_n_i = 1'b0;
    dac = def;
    repeat (6) @(posedge clk_i);
    #1;
    cmp_all();
    clear_pin_n_i = 1'b1;
    cmd(2, rnd());
    cmd(5, 0);
    stop_test();
  end
endmodule
